// ### src/ifp_top.sv
// Purpose: interrupt flags, enables, priorities and external pin triggers behind an APB slave
// Assumes: pins and events synchronous inputs to clk, events are one-cycle pulses
// Notes: zero-wait-state APB answer, unmapped index answers with pslverr
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "ifp_consts.svh"

module ifp_top
    import ifp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire ifp_evt_t    evt,
    input  wire ifp_clr_t    side_clr,
    input  wire logic [8:0]  g0_pin,
    input  wire logic [2:0]  ext_pin,
    input  wire logic [15:0] g4_pin,
    output ifp_req_t         core_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // trigger match for a two-bit field
    function automatic logic trig_hit(input logic [1:0] code, input logic rise, input logic fall);
        if (code == `IFP_TRIG_FALL) begin
            return fall;
        end else if (code == `IFP_TRIG_RISE) begin
            return rise;
        end
        return rise | fall;
    endfunction : trig_hit

    // index of lowest set bit, query order lsb first
    function automatic logic [4:0] first_set(input logic [`IFP_NSRC-1:0] v);
        logic [4:0] idx;
        idx = 5'h0;
        for (int i = `IFP_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : first_set

    logic [7:0]  sel1_r, sel2_r, sel3_r, sel4_r, sel5_r, con1_r, con2_r;
    logic [7:0]  en0_r, en1_r, en2_r, pri0_r, pri1_r, pri2_r;
    logic [7:0]  pstat_r, exstat_r, flg1_r, flg2_r, cflg_r;
    logic [7:0]  sel1_nxt, sel2_nxt, sel3_nxt, sel4_nxt, sel5_nxt, con1_nxt, con2_nxt;
    logic [7:0]  en0_nxt, en1_nxt, en2_nxt, pri0_nxt, pri1_nxt, pri2_nxt;
    logic [7:0]  pstat_nxt, exstat_nxt, flg1_nxt, flg2_nxt, cflg_nxt;
    logic [27:0] sync1_r, sync2_r, prev_r;
    logic [27:0] rise, fall;
    logic [7:0]  g0_hit;
    logic        p8_hit, ext1_hit, ext2_hit, ext3_hit, g4_hit;
    logic [15:0] g4_sel, g4_edge;
    logic        g4_idle;
    ifp_g4_state_t g4_state_r, g4_state_nxt;
    logic        wr_ok, idx_ok;
    logic [7:0]  idx, wd;
    logic [31:0] prdata_nxt;
    logic        pready_nxt, pslverr_nxt;
    logic [`IFP_NSRC-1:0] pend, prio, pend_hi;
    ifp_req_t    req_nxt;

    // two-stage synchroniser then previous sample for edges
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= 28'h000_0000;
            sync2_r <= 28'h000_0000;
            prev_r  <= 28'h000_0000;
        end else begin
            sync1_r <= {g4_pin, ext_pin, g0_pin};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end
    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;

    // group-0 pins 0..7 share one trigger field, pin 8 and the ext pins each have their own
    for (genvar i = 0; i < 8; i++) begin : g_g0
        assign g0_hit[i] = sel2_r[i] & trig_hit(con2_r[1:0], rise[i], fall[i]);
    end
    assign p8_hit   = sel1_r[0] & trig_hit(con1_r[1:0], rise[8], fall[8]);
    assign ext1_hit = sel1_r[1] & trig_hit(con1_r[3:2], rise[9], fall[9]);
    assign ext2_hit = sel1_r[2] & trig_hit(con1_r[5:4], rise[10], fall[10]);
    assign ext3_hit = sel1_r[3] & trig_hit(con1_r[7:6], rise[11], fall[11]);

    // group-4 pins 7..22 in one vector
    assign g4_sel  = {sel5_r[6:0], sel4_r, sel3_r[7]};
    assign g4_edge = con2_r[`IFP_BIT_G4EDGE] ? rise[27:12] : fall[27:12];
    assign g4_idle = &(~g4_sel | (con2_r[`IFP_BIT_G4EDGE] ? ~sync2_r[27:12] : sync2_r[27:12]));

    // group-4 arbiter: one trigger, then wait for all selected pins idle
    always_comb begin
        g4_state_nxt = g4_state_r;
        g4_hit       = 1'b0;
        case (g4_state_r)
            IFP_G4_ARMED: begin
                if (|(g4_sel & g4_edge)) begin
                    g4_hit       = 1'b1;
                    g4_state_nxt = IFP_G4_WAIT_IDLE;
                end
            end
            IFP_G4_WAIT_IDLE: begin
                if (g4_idle) begin
                    g4_state_nxt = IFP_G4_ARMED;
                end
            end
            default: g4_state_nxt = IFP_G4_WAIT_IDLE;
        endcase
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            g4_state_r <= IFP_G4_WAIT_IDLE;
        end else begin
            g4_state_r <= g4_state_nxt;
        end
    end
    // software may store a 1 into the flag directly, only hardware sets are checked
    a_g4_single_trigger: assert property ($rose(flg2_r[7]) && !$past(wr_ok && idx == `IFP_IDX_FLG2)
                                          |-> $past(g4_state_r) == IFP_G4_ARMED)
        else $error("group-4 flag set while not armed");

    // bus decode
    assign idx    = paddr[9:2];
    assign wd     = pwdata[7:0];
    assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                    (idx inside {`IFP_IDX_SEL1, `IFP_IDX_SEL2, `IFP_IDX_SEL3, `IFP_IDX_SEL4, `IFP_IDX_SEL5,
                                 `IFP_IDX_CON1, `IFP_IDX_CON2, `IFP_IDX_EN0, `IFP_IDX_PSTAT, `IFP_IDX_PRI0,
                                 `IFP_IDX_CFLG, `IFP_IDX_EXSTAT, `IFP_IDX_FLG2, `IFP_IDX_EN1, `IFP_IDX_EN2,
                                 `IFP_IDX_FLG1, `IFP_IDX_PRI2, `IFP_IDX_PRI1});
    assign wr_ok  = psel & penable & pready & pwrite & idx_ok;

    // register and flag next values, hardware set wins over any clear
    always_comb begin
        sel1_nxt = (wr_ok && idx == `IFP_IDX_SEL1) ? wd : sel1_r;
        sel2_nxt = (wr_ok && idx == `IFP_IDX_SEL2) ? wd : sel2_r;
        sel3_nxt = (wr_ok && idx == `IFP_IDX_SEL3) ? (wd & `IFP_MSK_SEL3) : sel3_r;
        sel4_nxt = (wr_ok && idx == `IFP_IDX_SEL4) ? wd : sel4_r;
        sel5_nxt = (wr_ok && idx == `IFP_IDX_SEL5) ? (wd & `IFP_MSK_SEL5) : sel5_r;
        con1_nxt = (wr_ok && idx == `IFP_IDX_CON1) ? wd : con1_r;
        con2_nxt = (wr_ok && idx == `IFP_IDX_CON2) ? (wd & `IFP_MSK_CON2) : con2_r;
        en0_nxt  = (wr_ok && idx == `IFP_IDX_EN0) ? (wd & `IFP_MSK_EN0) : en0_r;
        en1_nxt  = (wr_ok && idx == `IFP_IDX_EN1) ? (wd & `IFP_MSK_GRP1) : en1_r;
        en2_nxt  = (wr_ok && idx == `IFP_IDX_EN2) ? wd : en2_r;
        pri0_nxt = (wr_ok && idx == `IFP_IDX_PRI0) ? (wd & `IFP_MSK_PRI0) : pri0_r;
        pri1_nxt = (wr_ok && idx == `IFP_IDX_PRI1) ? (wd & `IFP_MSK_GRP1) : pri1_r;
        pri2_nxt = (wr_ok && idx == `IFP_IDX_PRI2) ? wd : pri2_r;

        // status flags: write 0 clears, writing 1 keeps
        pstat_nxt = pstat_r;
        if (wr_ok && idx == `IFP_IDX_PSTAT) begin
            pstat_nxt = pstat_r & wd;
        end
        if (side_clr.watchdog_control_reg_wr) begin
            pstat_nxt[`IFP_BIT_WDTST] = 1'b0;
        end
        if (side_clr.long_timer_config_reg_wr) begin
            pstat_nxt[`IFP_BIT_LTST] = 1'b0;
        end
        if (side_clr.scan_start_wr) begin
            pstat_nxt[`IFP_BIT_SEGST] = 1'b0;
            pstat_nxt[`IFP_BIT_DOTST] = 1'b0;
        end
        if (!sel1_r[0]) begin
            pstat_nxt[`IFP_BIT_P8ST] = 1'b0;
        end
        pstat_nxt[`IFP_BIT_T3ST]  = pstat_nxt[`IFP_BIT_T3ST]  | evt.timer3;
        pstat_nxt[`IFP_BIT_P8ST]  = pstat_nxt[`IFP_BIT_P8ST]  | p8_hit;
        pstat_nxt[`IFP_BIT_WDTST] = pstat_nxt[`IFP_BIT_WDTST] | evt.watchdog;
        pstat_nxt[`IFP_BIT_LTST]  = pstat_nxt[`IFP_BIT_LTST]  | evt.long_timer;
        pstat_nxt[`IFP_BIT_SEGST] = pstat_nxt[`IFP_BIT_SEGST] | evt.segment_display;
        pstat_nxt[`IFP_BIT_DOTST] = pstat_nxt[`IFP_BIT_DOTST] | evt.dot_matrix;

        // group-0 pin flags, held clear while deselected
        exstat_nxt = ((wr_ok && idx == `IFP_IDX_EXSTAT) ? (exstat_r & wd) : exstat_r) & sel2_r;
        exstat_nxt = exstat_nxt | g0_hit;

        // grouped request flags
        flg1_nxt = (wr_ok && idx == `IFP_IDX_FLG1) ? (wd & `IFP_MSK_GRP1) : flg1_r;
        flg1_nxt = flg1_nxt | {evt.watchdog | evt.long_timer,
                               evt.segment_display | evt.dot_matrix,
                               evt.touch_counter, evt.adc, evt.i2c, ext2_hit, 2'b00};
        flg2_nxt = (wr_ok && idx == `IFP_IDX_FLG2) ? wd : flg2_r;
        flg2_nxt = flg2_nxt | {g4_hit, ext3_hit, evt.spi, evt.timer3, evt.uart1, evt.uart0,
                               evt.low_voltage_detector, evt.serial_port_2};
        cflg_nxt = (wr_ok && idx == `IFP_IDX_CFLG) ? (wd & `IFP_MSK_CFLG) : cflg_r;
        cflg_nxt = cflg_nxt | {4'h0, evt.timer1, ext1_hit, evt.timer0, (|g0_hit) | p8_hit};
    end

    // register bank
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel1_r   <= `IFP_RST_SEL1;
            sel2_r   <= 8'h00;
            sel3_r   <= 8'h00;
            sel4_r   <= 8'h00;
            sel5_r   <= 8'h00;
            con1_r   <= `IFP_RST_CON1;
            con2_r   <= `IFP_RST_CON2;
            en0_r    <= 8'h00;
            en1_r    <= 8'h00;
            en2_r    <= 8'h00;
            pri0_r   <= 8'h00;
            pri1_r   <= 8'h00;
            pri2_r   <= 8'h00;
            pstat_r  <= 8'h00;
            exstat_r <= 8'h00;
            flg1_r   <= 8'h00;
            flg2_r   <= 8'h00;
            cflg_r   <= 8'h00;
        end else begin
            sel1_r   <= sel1_nxt;
            sel2_r   <= sel2_nxt;
            sel3_r   <= sel3_nxt;
            sel4_r   <= sel4_nxt;
            sel5_r   <= sel5_nxt;
            con1_r   <= con1_nxt;
            con2_r   <= con2_nxt;
            en0_r    <= en0_nxt;
            en1_r    <= en1_nxt;
            en2_r    <= en2_nxt;
            pri0_r   <= pri0_nxt;
            pri1_r   <= pri1_nxt;
            pri2_r   <= pri2_nxt;
            pstat_r  <= pstat_nxt;
            exstat_r <= exstat_nxt;
            flg1_r   <= flg1_nxt;
            flg2_r   <= flg2_nxt;
            cflg_r   <= cflg_nxt;
        end
    end
    a_wdt_side_clear: assert property (side_clr.watchdog_control_reg_wr && !evt.watchdog |=> !pstat_r[4])
        else $error("watchdog flag not cleared by control write");
    a_lt_side_clear: assert property (side_clr.long_timer_config_reg_wr && !evt.long_timer |=> !pstat_r[3])
        else $error("long timer flag not cleared by config write");
    a_scan_clear_pair: assert property (side_clr.scan_start_wr && !evt.segment_display && !evt.dot_matrix
                                        |=> pstat_r[1:0] == 2'b00)
        else $error("display flags not cleared by scan start");
    a_g0_desel_clear: assert property (sel2_r == 8'h00 |=> exstat_r == 8'h00)
        else $error("group-0 flag pending while deselected");
    a_ext2_fall_edge: assert property (sel1_r[2] && con1_r[5:4] == 2'h1 && fall[10] |=> flg1_r[2])
        else $error("falling edge on ext2 did not set flag");
    a_g0_no_wrong_edge: assert property (sel2_r[0] && con2_r[1:0] == 2'h2 && fall[0] && !exstat_r[0]
                                         |=> !exstat_r[0])
        else $error("group-0 pin 0 set on wrong edge");
    a_evt_sets_flag: assert property (evt.spi |=> flg2_r[5])
        else $error("event lost against a clear");

    // pending sources in query order, masked by global enable
    always_comb begin
        pend    = {flg2_r & en2_r, flg1_r[7:2] & en1_r[7:2], cflg_r[3:0] & en0_r[3:0]};
        pend    = en0_r[`IFP_BIT_GLOBAL] ? pend : '0;
        prio    = {pri2_r, pri1_r[7:2], pri0_r[3:0]};
        pend_hi = pend & prio;
        req_nxt.req  = |pend;
        req_nxt.high = |pend_hi;
        req_nxt.src  = (|pend_hi) ? first_set(pend_hi) : first_set(pend);
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_req <= '0;
        end else begin
            core_req <= req_nxt;
        end
    end
    a_global_mask: assert property (!en0_r[7] |=> !core_req.req)
        else $error("request raised with global enable off");
    a_high_first: assert property (|(pend & prio) |=> core_req.high && prio[core_req.src])
        else $error("low request presented over high");
    a_req_cause: assert property (core_req.req |-> $past(en0_r[7]) && $past(|pend))
        else $error("request without enabled pending flag");

    // apb answer one cycle after the setup phase
    always_comb begin
        pready_nxt  = psel & ~penable;
        pslverr_nxt = psel & ~penable & ~idx_ok;
        prdata_nxt  = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (idx)
                `IFP_IDX_SEL1:   prdata_nxt[7:0] = sel1_r;
                `IFP_IDX_SEL2:   prdata_nxt[7:0] = sel2_r;
                `IFP_IDX_SEL3:   prdata_nxt[7:0] = sel3_r;
                `IFP_IDX_SEL4:   prdata_nxt[7:0] = sel4_r;
                `IFP_IDX_SEL5:   prdata_nxt[7:0] = sel5_r;
                `IFP_IDX_CON1:   prdata_nxt[7:0] = con1_r;
                `IFP_IDX_CON2:   prdata_nxt[7:0] = con2_r;
                `IFP_IDX_EN0:    prdata_nxt[7:0] = en0_r;
                `IFP_IDX_PSTAT:  prdata_nxt[7:0] = pstat_r & `IFP_MSK_PSTAT;
                `IFP_IDX_PRI0:   prdata_nxt[7:0] = pri0_r;
                `IFP_IDX_CFLG:   prdata_nxt[7:0] = cflg_r;
                `IFP_IDX_EXSTAT: prdata_nxt[7:0] = exstat_r;
                `IFP_IDX_FLG2:   prdata_nxt[7:0] = flg2_r;
                `IFP_IDX_EN1:    prdata_nxt[7:0] = en1_r;
                `IFP_IDX_EN2:    prdata_nxt[7:0] = en2_r;
                `IFP_IDX_FLG1:   prdata_nxt[7:0] = flg1_r;
                `IFP_IDX_PRI2:   prdata_nxt[7:0] = pri2_r;
                `IFP_IDX_PRI1:   prdata_nxt[7:0] = pri1_r;
                default:         prdata_nxt[7:0] = 8'h00;
            endcase
            if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
                prdata_nxt = 32'h0000_0000;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end
endmodule : ifp_top

// ### src/ifp_consts.svh
// Purpose: register indices, reset values, masks and field positions of the flag and priority block
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef IFP_CONSTS_SVH
`define IFP_CONSTS_SVH

// register indices
`define IFP_IDX_SEL1   8'h34
`define IFP_IDX_SEL2   8'h35
`define IFP_IDX_SEL3   8'h36
`define IFP_IDX_SEL4   8'h37
`define IFP_IDX_SEL5   8'h38
`define IFP_IDX_CON1   8'h39
`define IFP_IDX_CON2   8'h3A
`define IFP_IDX_EN0    8'hA8
`define IFP_IDX_PSTAT  8'hAE
`define IFP_IDX_PRI0   8'hB8
`define IFP_IDX_CFLG   8'hC0
`define IFP_IDX_EXSTAT 8'hC7
`define IFP_IDX_FLG2   8'hE1
`define IFP_IDX_EN1    8'hE6
`define IFP_IDX_EN2    8'hE7
`define IFP_IDX_FLG1   8'hF1
`define IFP_IDX_PRI2   8'hF4
`define IFP_IDX_PRI1   8'hF6

// reset values of registers that do not reset to zero
`define IFP_RST_SEL1   8'h10
`define IFP_RST_CON1   8'h55
`define IFP_RST_CON2   8'h01

// implemented bits, the rest read as zero
`define IFP_MSK_SEL3   8'h80
`define IFP_MSK_SEL5   8'h7F
`define IFP_MSK_CON2   8'h07
`define IFP_MSK_EN0    8'h8F
`define IFP_MSK_PRI0   8'h0F
`define IFP_MSK_CFLG   8'h0F
`define IFP_MSK_GRP1   8'hFC
`define IFP_MSK_PSTAT  8'h7B

// field positions
`define IFP_BIT_GLOBAL 7
`define IFP_BIT_G4EDGE 2
`define IFP_BIT_T3ST   6
`define IFP_BIT_P8ST   5
`define IFP_BIT_WDTST  4
`define IFP_BIT_LTST   3
`define IFP_BIT_SEGST  1
`define IFP_BIT_DOTST  0

// trigger field codes
`define IFP_TRIG_FALL  2'h1
`define IFP_TRIG_RISE  2'h2

// number of sources in query order
`define IFP_NSRC       18
`endif

// ### src/ifp_pkg.sv
// Purpose: types of the flag and priority block
// Assumes: used together with ifp_consts.svh
// Notes: event and clear pulses travel as packed structs
package ifp_pkg;
    // one-cycle source events from peripherals
    typedef struct packed {
        logic timer0;
        logic timer1;
        logic i2c;
        logic adc;
        logic touch_counter;
        logic watchdog;
        logic long_timer;
        logic segment_display;
        logic dot_matrix;
        logic serial_port_2;
        logic low_voltage_detector;
        logic uart0;
        logic uart1;
        logic timer3;
        logic spi;
    } ifp_evt_t;

    // side-effect clears from writes to registers of other blocks
    typedef struct packed {
        logic watchdog_control_reg_wr;
        logic long_timer_config_reg_wr;
        logic scan_start_wr;
    } ifp_clr_t;

    // request presented to the core
    typedef struct packed {
        logic       req;
        logic       high;
        logic [4:0] src;
    } ifp_req_t;

    typedef enum logic [0:0] {
        IFP_G4_WAIT_IDLE = 1'b0,
        IFP_G4_ARMED     = 1'b1
    } ifp_g4_state_t;
endpackage : ifp_pkg

// ### bench/ifp_partner.sv
// Purpose: far-side model, peripherals raising events and external parts driving pins
// Assumes: bench asks for one-cycle events and pin levels
// Notes: group-4 release puts every pin at the idle level of the chosen edge
`timescale 1ns/1ps
module ifp_partner
    import ifp_pkg::*;
(
    input  wire logic        clk,
    input  wire ifp_evt_t    evt_req,
    input  wire logic [8:0]  g0_req,
    input  wire logic [2:0]  ext_req,
    input  wire logic [15:0] g4_req,
    input  wire logic        g4_rel,
    input  wire logic        g4_rise,
    output ifp_evt_t         evt,
    output logic [8:0]       g0_pin,
    output logic [2:0]       ext_pin,
    output logic [15:0]      g4_pin
);
    // events and pin levels change just after the clock edge
    always_ff @(posedge clk) begin
        evt     <= evt_req;
        g0_pin  <= g0_req;
        ext_pin <= ext_req;
        g4_pin  <= g4_rel ? {16{~g4_rise}} : g4_req;
    end
endmodule : ifp_partner

// ### bench/test_interrupt_flags_priority_extint.sv
// Purpose: self-checking bench of the flag and priority block
// Assumes: far side driven through ifp_partner
// Notes: reads queue their expectation, a monitor compares
`timescale 1ns/1ps
`include "ifp_consts.svh"
module test_interrupt_flags_priority_extint
    import ifp_pkg::*;
;
    logic        clk = 1'b0, sys_rst = 1'b1, g4_rel = 1'b0, g4_rise = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [8:0]  g0_req = 9'h000, g0_pin;
    logic [2:0]  ext_req = 3'h0, ext_pin;
    logic [15:0] g4_req = 16'h0000, g4_pin;
    logic [7:0]  lfsr = 8'h59;
    logic [8:0]  exp_q[$];
    ifp_evt_t    evt_req = '0, evt;
    ifp_clr_t    side_clr = '0;
    ifp_req_t    core_req;
    int          bad_count = 0, num_checks = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    ifp_top ifp_top_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .evt, .side_clr, .g0_pin, .ext_pin, .g4_pin, .core_req);
    ifp_partner ifp_partner_inst (.clk, .evt_req, .g0_req, .ext_req, .g4_req, .g4_rel, .g4_rise,
        .evt, .g0_pin, .ext_pin, .g4_pin);

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next

    function automatic void cmp(input string what, input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endfunction : cmp

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic err);
        exp_q.push_back({err, d});
        apb(1'b0, idx, 8'h00);
    endtask : rd

    // one-cycle event and side-clear pulses, then let flags settle
    task automatic pulse(input ifp_evt_t e, input ifp_clr_t c);
        evt_req  <= e;
        side_clr <= c;
        @(posedge clk);
        evt_req  <= '0;
        side_clr <= '0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic rq(input logic r, input logic h, input logic [4:0] s);
        @(negedge clk);
        cmp("core_req", {2'b00, core_req.req, r ? {core_req.high, core_req.src} : 6'h00}, {2'b00, r, h, s});
        @(posedge clk);
    endtask : rq

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    // read monitor takes the oldest expectation at the edge that ends the access
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp("read", {pslverr, prdata[7:0]}, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1FF);
    end

    // watchdog against a hang
    initial begin
        #100000;
        bad_count++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(`IFP_IDX_SEL1, 8'h10, 1'b0);
        rd(`IFP_IDX_CON1, 8'h55, 1'b0);
        rd(`IFP_IDX_CON2, 8'h01, 1'b0);
        rd(8'h00, 8'h00, 1'b1);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(`IFP_IDX_PRI1, lfsr);
            rd(`IFP_IDX_PRI1, lfsr & 8'hFC, 1'b0);
            wr(`IFP_IDX_PRI0, lfsr);
            rd(`IFP_IDX_PRI0, lfsr & 8'h0F, 1'b0);
            wr(`IFP_IDX_EN1, lfsr);
            rd(`IFP_IDX_EN1, lfsr & 8'hFC, 1'b0);
        end
        wr(`IFP_IDX_EN1, 8'h00);
        wr(`IFP_IDX_SEL3, 8'hFF);
        rd(`IFP_IDX_SEL3, 8'h80, 1'b0);
        wr(`IFP_IDX_SEL3, 8'h00);
        $display("test registers done");
        wr(`IFP_IDX_EN2, 8'h30);
        pulse('{spi: 1'b1, timer3: 1'b1, default: 1'b0}, '0);
        rd(`IFP_IDX_FLG2, 8'h30, 1'b0);
        rq(1'b0, 1'b0, 5'd0);
        wr(`IFP_IDX_EN0, 8'h80);
        rq(1'b1, 1'b0, 5'd14);
        wr(`IFP_IDX_PRI2, 8'h20);
        rq(1'b1, 1'b1, 5'd15);
        wr(`IFP_IDX_EN2, 8'h10);
        rq(1'b1, 1'b0, 5'd14);
        wr(`IFP_IDX_FLG2, 8'h00);
        rq(1'b0, 1'b0, 5'd0);
        // timer3 status bit 6 stays set from the first pulse
        pulse('{watchdog: 1'b1, long_timer: 1'b1, segment_display: 1'b1, default: 1'b0}, '0);
        rd(`IFP_IDX_PSTAT, 8'h5A, 1'b0);
        rd(`IFP_IDX_FLG1, 8'hC0, 1'b0);
        pulse('0, '{watchdog_control_reg_wr: 1'b1, default: 1'b0});
        rd(`IFP_IDX_PSTAT, 8'h4A, 1'b0);
        wr(`IFP_IDX_PSTAT, 8'hF7);
        rd(`IFP_IDX_PSTAT, 8'h42, 1'b0);
        pulse('0, '{scan_start_wr: 1'b1, default: 1'b0});
        rd(`IFP_IDX_PSTAT, 8'h40, 1'b0);
        $display("test flags done");
        wr(`IFP_IDX_SEL1, 8'h12);
        for (int c = 0; c < 4; c++) begin
            wr(`IFP_IDX_CON1, {4'h5, c[1:0], 2'h1});
            wr(`IFP_IDX_CFLG, 8'h00);
            ext_req <= 3'h1;
            repeat (6) @(posedge clk);
            rd(`IFP_IDX_CFLG, (c == 1) ? 8'h00 : 8'h04, 1'b0);
            wr(`IFP_IDX_CFLG, 8'h00);
            ext_req <= 3'h0;
            repeat (6) @(posedge clk);
            rd(`IFP_IDX_CFLG, (c == 2) ? 8'h00 : 8'h04, 1'b0);
        end
        wr(`IFP_IDX_CON2, 8'h06);
        wr(`IFP_IDX_SEL2, 8'h01);
        wr(`IFP_IDX_SEL4, 8'h03);
        g0_req <= 9'h001;
        g4_req <= 16'h0002;
        repeat (6) @(posedge clk);
        rd(`IFP_IDX_EXSTAT, 8'h01, 1'b0);
        rd(`IFP_IDX_FLG2, 8'h80, 1'b0);
        wr(`IFP_IDX_SEL2, 8'h00);
        rd(`IFP_IDX_EXSTAT, 8'h00, 1'b0);
        wr(`IFP_IDX_FLG2, 8'h00);
        g4_req <= 16'h0006;
        repeat (6) @(posedge clk);
        rd(`IFP_IDX_FLG2, 8'h00, 1'b0);
        g4_rise <= 1'b1;
        g4_rel  <= 1'b1;
        repeat (4) @(posedge clk);
        g4_rel <= 1'b0;
        g4_req <= 16'h0004;
        repeat (6) @(posedge clk);
        rd(`IFP_IDX_FLG2, 8'h80, 1'b0);
        $display("test pins done");
        final_report();
    end
endmodule : test_interrupt_flags_priority_extint
